//--- logic/aux_cfg_pkg.sv
// Purpose: constants for the test-voltage, pin and secondary converter bank
// Assumes: byte addresses are printed offsets times four
// Notes: every register is eight bits in the low lane of a 32-bit word
package aux_cfg_pkg;
  // ***********************************************************
  // register indices and byte addresses
  // ***********************************************************
  localparam logic [7:0] IDX_POS_TEST = 8'h10;
  localparam logic [7:0] IDX_NEG_TEST = 8'h11;
  localparam logic [7:0] IDX_PIN_SHARE = 8'h12;
  localparam logic [7:0] IDX_PIN_DIR = 8'h13;
  localparam logic [7:0] IDX_PIN_DATA = 8'h14;
  localparam logic [7:0] IDX_AUX_CFG = 8'h15;
  localparam logic [7:0] IDX_AUX_MUX = 8'h16;
  localparam logic [7:0] IDX_OFS_LO = 8'h17;
  localparam logic [7:0] IDX_OFS_HI = 8'h18;
  localparam logic [7:0] IDX_FS_LO = 8'h19;
  localparam logic [7:0] IDX_FS_HI = 8'h1a;
  localparam int ADDR_W = 8;
  localparam int IDX_SHIFT = 2;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AUX_MUX = 8'h01;
  localparam logic [7:0] RST_FS_HI = 8'h40;

  // ***********************************************************
  // field positions
  // ***********************************************************
  localparam int TEST_ROUTE_BIT = 7;
  localparam int LEVEL_HI = 4;
  localparam int RATE_HI = 7;
  localparam int RATE_LO = 6;
  localparam int REF_HI = 5;
  localparam int REF_LO = 3;
  localparam int GAIN_HI = 2;
  localparam int POS_IN_HI = 7;
  localparam int POS_IN_LO = 4;
  localparam int NEG_IN_HI = 3;
  localparam logic [7:0] TEST_WR_MASK = 8'h9f;

  // ***********************************************************
  // calibration datapath
  // ***********************************************************
  localparam int CONV_W = 24;
  localparam int CAL_W = 16;
  localparam int OFS_SHIFT = CONV_W - CAL_W;
  localparam int FS_UNITY_LOG2 = 14;
  localparam logic [4:0] LEVEL_TOP_UP = 5'h09;
  localparam logic [4:0] LEVEL_BOT_DN = 5'h11;
  localparam logic [4:0] LEVEL_TOP_DN = 5'h19;
  localparam logic [2:0] REF_TOP = 3'h4;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_OFFSET = 3'b010,
    CAL_SCALE = 3'b100
  } cal_state_e;
endpackage

//--- logic/aux_cfg_regs.sv
// Purpose: register bank for test-voltage generators, shared pins and the
//   secondary converter, with its offset and full-scale correction
// Assumes: apb slave, zero wait states; rst synchronous, active high
// Notes: pin inputs are double-registered before any logic sees them
//
// Behaviour
// - route bit connects positive test output to input 6
// - positive level code decoded, reserved codes flagged
// - route bit connects negative test output to input 7
// - negative level uses same code table
// - share bit n joins pin n to analog input
// - direction 0 output, 1 input; reset outputs
// - data read of output pin returns zero
// - data write to input pin stores only
// - rate field selects four sample rates
// - reference field selects five sources
// - gain field selects power-of-two gain
// - positive input select field drives mux
// - negative input select resets to input 1
// - offset word sign-extended, shifted to 24 bits
// - offset subtracted before full-scale step
// - full-scale word unsigned, divided by 4000h
// - corrected result multiplied by scale factor
//
// The APB register port was decided locally.
module aux_cfg_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOutEnN,
  output logic [7:0] pinShareBits,
  output logic posTestRoute,
  output logic [4:0] posTestLevel,
  output logic posLevelReserved,
  output logic negTestRoute,
  output logic [4:0] negTestLevel,
  output logic negLevelReserved,
  output logic [1:0] auxRateField,
  output logic [2:0] auxRefField,
  output logic auxRefReserved,
  output logic [2:0] auxGainField,
  output logic [3:0] auxPosInput,
  output logic [3:0] auxNegInput,
  input wire logic convValid,
  input wire logic [23:0] convData,
  output logic calValid,
  output logic [23:0] calData
);
  // ***********************************************************
  // helpers
  // ***********************************************************
  // true for the nineteen defined test level codes
  function automatic logic levelOk(input logic [4:0] c);
    levelOk = (c <= aux_cfg_pkg::LEVEL_TOP_UP) ||
      ((c >= aux_cfg_pkg::LEVEL_BOT_DN) &&
       (c <= aux_cfg_pkg::LEVEL_TOP_DN));
  endfunction

  function automatic logic [23:0] sat24(input logic signed [41:0] v);
    if (v > 42'sh7fffff) begin
      sat24 = 24'h7fffff;
    end else if (v < -42'sh800000) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // ***********************************************************
  // apb decode
  // ***********************************************************
  logic [7:0] posTest_r, negTest_r, share_r, dir_r, data_r;
  logic [7:0] auxCfg_r, auxMux_r, ofsLo_r, ofsHi_r, fsLo_r, fsHi_r;
  logic [7:0] pinMeta_r, pinSync_r;
  logic [7:0] regIdx;
  logic addrOk, wrEn, lane0;

  assign regIdx = paddr[aux_cfg_pkg::ADDR_W + aux_cfg_pkg::IDX_SHIFT - 1:
                        aux_cfg_pkg::IDX_SHIFT];
  assign addrOk = (paddr[1:0] == 2'h0) &&
    (paddr[31:aux_cfg_pkg::ADDR_W + aux_cfg_pkg::IDX_SHIFT] == '0) &&
    (regIdx >= aux_cfg_pkg::IDX_POS_TEST) &&
    (regIdx <= aux_cfg_pkg::IDX_FS_HI);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;
  assign lane0 = pstrb[0];
  assign wrEn = psel && penable && pwrite && addrOk && lane0;

  function automatic logic hit(input logic [7:0] idx);
    hit = wrEn && (regIdx == idx);
  endfunction

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      posTest_r <= aux_cfg_pkg::RST_ZERO;
      negTest_r <= aux_cfg_pkg::RST_ZERO;
    end else begin
      // reserved bits 6:5 are never stored
      if (hit(aux_cfg_pkg::IDX_POS_TEST)) begin
        posTest_r <= pwdata[7:0] & aux_cfg_pkg::TEST_WR_MASK;
      end
      if (hit(aux_cfg_pkg::IDX_NEG_TEST)) begin
        negTest_r <= pwdata[7:0] & aux_cfg_pkg::TEST_WR_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      share_r <= aux_cfg_pkg::RST_ZERO;
      dir_r <= aux_cfg_pkg::RST_ZERO;
      data_r <= aux_cfg_pkg::RST_ZERO;
    end else begin
      if (hit(aux_cfg_pkg::IDX_PIN_SHARE)) begin
        share_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_PIN_DIR)) begin
        dir_r <= pwdata[7:0];
      end
      // inputs store the written value only; outputs drive it
      if (hit(aux_cfg_pkg::IDX_PIN_DATA)) begin
        data_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      auxCfg_r <= aux_cfg_pkg::RST_ZERO;
      auxMux_r <= aux_cfg_pkg::RST_AUX_MUX;
      ofsLo_r <= aux_cfg_pkg::RST_ZERO;
      ofsHi_r <= aux_cfg_pkg::RST_ZERO;
      fsLo_r <= aux_cfg_pkg::RST_ZERO;
      fsHi_r <= aux_cfg_pkg::RST_FS_HI;
    end else begin
      if (hit(aux_cfg_pkg::IDX_AUX_CFG)) begin
        auxCfg_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_AUX_MUX)) begin
        auxMux_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_OFS_LO)) begin
        ofsLo_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_OFS_HI)) begin
        ofsHi_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_FS_LO)) begin
        fsLo_r <= pwdata[7:0];
      end
      if (hit(aux_cfg_pkg::IDX_FS_HI)) begin
        fsHi_r <= pwdata[7:0];
      end
    end
  end

  // pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // ***********************************************************
  // read path
  // ***********************************************************
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (regIdx)
      aux_cfg_pkg::IDX_POS_TEST: rdByte = posTest_r;
      aux_cfg_pkg::IDX_NEG_TEST: rdByte = negTest_r;
      aux_cfg_pkg::IDX_PIN_SHARE: rdByte = share_r;
      aux_cfg_pkg::IDX_PIN_DIR: rdByte = dir_r;
      // output pins read zero, input pins read the pin level
      aux_cfg_pkg::IDX_PIN_DATA: rdByte = pinSync_r & dir_r;
      aux_cfg_pkg::IDX_AUX_CFG: rdByte = auxCfg_r;
      aux_cfg_pkg::IDX_AUX_MUX: rdByte = auxMux_r;
      aux_cfg_pkg::IDX_OFS_LO: rdByte = ofsLo_r;
      aux_cfg_pkg::IDX_OFS_HI: rdByte = ofsHi_r;
      aux_cfg_pkg::IDX_FS_LO: rdByte = fsLo_r;
      aux_cfg_pkg::IDX_FS_HI: rdByte = fsHi_r;
      default: rdByte = 8'h00;
    endcase
  end

  // data comes from a flop, captured in the setup cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, addrOk ? rdByte : 8'h00};
    end
  end

  // ***********************************************************
  // field outputs
  // ***********************************************************
  assign posTestRoute = posTest_r[aux_cfg_pkg::TEST_ROUTE_BIT];
  assign posTestLevel = posTest_r[aux_cfg_pkg::LEVEL_HI:0];
  // reserved codes are flagged, not corrected: software owns them
  assign posLevelReserved = !levelOk(posTestLevel);
  assign negTestRoute = negTest_r[aux_cfg_pkg::TEST_ROUTE_BIT];
  assign negTestLevel = negTest_r[aux_cfg_pkg::LEVEL_HI:0];
  assign negLevelReserved = !levelOk(negTestLevel);
  assign pinShareBits = share_r;
  assign pinOut = data_r & ~dir_r;
  assign pinOutEnN = dir_r;
  assign auxRateField =
    auxCfg_r[aux_cfg_pkg::RATE_HI:aux_cfg_pkg::RATE_LO];
  assign auxRefField =
    auxCfg_r[aux_cfg_pkg::REF_HI:aux_cfg_pkg::REF_LO];
  assign auxRefReserved = auxRefField > aux_cfg_pkg::REF_TOP;
  assign auxGainField = auxCfg_r[aux_cfg_pkg::GAIN_HI:0];
  assign auxPosInput =
    auxMux_r[aux_cfg_pkg::POS_IN_HI:aux_cfg_pkg::POS_IN_LO];
  assign auxNegInput = auxMux_r[aux_cfg_pkg::NEG_IN_HI:0];
  // rate codes 00..11 go straight to the decimator

  // ***********************************************************
  // calibration: offset then scale, one cycle each
  // ***********************************************************
  aux_cfg_pkg::cal_state_e calState_r;
  logic signed [24:0] diff_r;
  logic signed [23:0] ofsAligned;
  logic signed [41:0] prod;

  // low byte first; sign lives in the high byte
  assign ofsAligned = $signed({ofsHi_r, ofsLo_r,
                               {aux_cfg_pkg::OFS_SHIFT{1'b0}}});
  assign prod = diff_r * $signed({1'b0, fsHi_r, fsLo_r});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      calState_r <= aux_cfg_pkg::CAL_IDLE;
      diff_r <= '0;
      calData <= '0;
      calValid <= 1'b0;
    end else begin
      calValid <= 1'b0;
      case (calState_r)
        aux_cfg_pkg::CAL_IDLE: begin
          if (convValid) begin
            calState_r <= aux_cfg_pkg::CAL_OFFSET;
            diff_r <= 25'($signed(convData)) -
              25'(ofsAligned);
          end
        end
        aux_cfg_pkg::CAL_OFFSET: begin
          calState_r <= aux_cfg_pkg::CAL_IDLE;
          // divide by 4000h, unsigned word
          calData <= sat24(prod >>> aux_cfg_pkg::FS_UNITY_LOG2);
          calValid <= 1'b1;
        end
        default: calState_r <= aux_cfg_pkg::CAL_IDLE;
      endcase
    end
  end
endmodule

//--- verif/aux_cfg_props.sv
// Purpose: port checks on the register bank
// Assumes: zero-wait apb, byte address is index times four
// Notes: bound into every bank instance
module aux_cfg_props (
  input wire logic sys_clk, rst, psel, penable, pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] paddr, pwdata, prdata,
  input wire logic posTestRoute, negTestRoute, posLevelReserved,
  input wire logic convValid, calValid,
  input wire logic [7:0] pinOut, pinOutEnN,
  input wire logic [4:0] posTestLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************
  // properties
  // ************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr, rd;
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  sequence s_wr(a); wr && paddr == a; endsequence
  sequence s_cal; convValid ##1 !calValid ##1 calValid; endsequence
  property p_rtp; s_wr(32'h40) |=> posTestRoute == $past(pwdata[7]);
  endproperty
  a_rtp: assert property (p_rtp) else $error("pos route");
  property p_lvl; s_wr(32'h40) |=> posTestLevel == $past(pwdata[4:0]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("pos level");
  property p_rsv; posLevelReserved == !(posTestLevel <= 5'h09 ||
    posTestLevel inside {[5'h11:5'h19]}); endproperty
  a_rsv: assert property (p_rsv) else $error("level flag");
  property p_rtn; s_wr(32'h44) |=> negTestRoute == $past(pwdata[7]);
  endproperty
  a_rtn: assert property (p_rtn) else $error("neg route");
  property p_dir; s_wr(32'h4c) |=> pinOutEnN == $past(pwdata[7:0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_pin; (pinOut & pinOutEnN) == 8'h00; endproperty
  a_pin: assert property (p_pin) else $error("input pin driven");
  property p_rd; rd && paddr == 32'h50 |->
    (prdata[7:0] & ~pinOutEnN) == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("output bit read");
  property p_cal; $rose(convValid) |-> s_cal; endproperty
  a_cal: assert property (p_cal) else $error("cal latency");
endmodule

bind aux_cfg_regs aux_cfg_props chk (.sys_clk(sys_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pstrb(pstrb),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pinOut(pinOut),
  .posTestRoute(posTestRoute), .negTestRoute(negTestRoute),
  .posLevelReserved(posLevelReserved), .convValid(convValid),
  .calValid(calValid), .pinOutEnN(pinOutEnN),
  .posTestLevel(posTestLevel));

//--- verif/pin_partner.sv
// Purpose: board side of the eight shared pins
// Assumes: enable low means the bank drives the pin
// Notes: undriven pins follow the level the bench chooses
module pin_partner (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOutEnN,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // an input pin is never driven by the bank, so the board wins
  assign pinIn = (pinOut & ~pinOutEnN) | (extLevel & pinOutEnN);
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the register bank
// Assumes: apb answer taken when pready is high
// Notes: seeded random values with corner cases first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, convValid = 1'h0;
  logic [3:0] pstrb = 4'hf, auxPosInput, auxNegInput;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [23:0] convData = 24'h0, calData;
  logic [7:0] extLevel = 8'h0, pinIn, pinOut, pinOutEnN, pinShareBits;
  logic pready, pslverr, posTestRoute, negTestRoute, calValid;
  logic posLevelReserved, negLevelReserved, auxRefReserved;
  logic [4:0] posTestLevel, negTestLevel;
  logic [1:0] auxRateField;
  logic [2:0] auxRefField, auxGainField;
  int fails = 0, check_count = 0, seed = 44609;
  always #2.5 sys_clk = ~sys_clk;
  aux_cfg_regs uut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .pinShareBits(pinShareBits), .posTestRoute(posTestRoute),
    .posTestLevel(posTestLevel), .posLevelReserved(posLevelReserved),
    .negTestRoute(negTestRoute), .negTestLevel(negTestLevel),
    .negLevelReserved(negLevelReserved), .auxRateField(auxRateField),
    .auxRefField(auxRefField), .auxRefReserved(auxRefReserved),
    .auxGainField(auxGainField), .auxPosInput(auxPosInput),
    .auxNegInput(auxNegInput), .convValid(convValid),
    .convData(convData), .calValid(calValid), .calData(calData));
  pin_partner pins (.pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .extLevel(extLevel), .pinIn(pinIn));
  // ************************************
  // bus tasks and expectations
  // ************************************
  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [7:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) begin
      fails++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'h1, a, d, q, e);
    @(negedge sys_clk);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] q;
    logic r;
    xfer(1'h0, a, 8'h0, q, r);
    chk("register", q, e);
  endtask
  // offset first, then the unsigned scale, then saturation
  function automatic logic [23:0] calx(logic [23:0] c, logic [15:0] o, f);
    longint p;
    p = (longint'($signed(c)) - (longint'($signed(o)) <<< 8)) * longint'(f);
    p = p >>> 14;
    if (p > 64'sh7fffff) p = 64'sh7fffff;
    if (p < -64'sh800000) p = -64'sh800000;
    return p[23:0];
  endfunction
  initial begin
    logic [31:0] q, v;
    logic [23:0] c;
    logic e;
    int i, n;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    for (i = 0; i < 11; i++)
      rdc(32'h40 + 4 * i, i == 6 ? 32'h1 : i == 10 ? 32'h40 : 32'h0);
    chk("enN", pinOutEnN, 32'h0);
    $display("reset test done");
    // the host only ever writes the nineteen defined level codes
    for (i = 0; i < 38; i++) begin
      v = (i % 19 < 10 ? i % 19 : i % 19 + 7) | ($random(seed) & 32'h80);
      wr(i < 19 ? 32'h40 : 32'h44, v[7:0]);
      chk("route", i < 19 ? posTestRoute : negTestRoute, v[7]);
      chk("level", i < 19 ? posTestLevel : negTestLevel, v[4:0]);
      chk("rsv", posLevelReserved | negLevelReserved, 32'h0);
      rdc(i < 19 ? 32'h40 : 32'h44, v);
    end
    $display("test voltage test done");
    for (i = 0; i < 8; i++) begin
      v = i == 0 ? 32'hffff00 : i == 1 ? 32'hffff : $random(seed);
      wr(32'h4c, v[7:0]);
      wr(32'h50, v[15:8]);
      wr(32'h48, v[15:8]);
      @(posedge sys_clk);
      extLevel <= v[23:16];
      repeat (3) @(posedge sys_clk);
      chk("enN", pinOutEnN, v[7:0]);
      chk("pinOut", pinOut, v[15:8] & ~v[7:0]);
      chk("share", pinShareBits, v[15:8]);
      rdc(32'h50, v[23:16] & v[7:0]);
    end
    $display("pin test done");
    for (i = 0; i < 24; i++) begin
      v = i < 16 ? i * 32'h110000 | (i & 7) * 32'h49 : $random(seed);
      wr(32'h54, v[7:0]);
      wr(32'h58, v[23:16]);
      chk("rate", auxRateField, v[7:6]);
      chk("ref", auxRefField, v[5:3]);
      chk("refRsv", auxRefReserved, v[5:3] > 3'h4);
      chk("gain", auxGainField, v[2:0]);
      chk("posIn", auxPosInput, v[23:20]);
      chk("negIn", auxNegInput, v[19:16]);
    end
    $display("converter setup test done");
    for (i = 0; i < 12; i++) begin
      v = i < 2 ? 32'h40000000 : $random(seed);
      c = i == 1 ? 24'h800000 : $random(seed);
      wr(32'h5c, v[7:0]);
      wr(32'h60, v[15:8]);
      wr(32'h64, v[23:16]);
      wr(32'h68, v[31:24]);
      @(posedge sys_clk);
      convData <= c;
      convValid <= 1'h1;
      @(posedge sys_clk);
      convValid <= 1'h0;
      for (n = 0; n < 8 && calValid !== 1'h1; n++) @(negedge sys_clk);
      chk("calValid", n < 8, 32'h1);
      chk("calData", calData, calx(c, v[15:0], v[31:16]));
      if (n == 8) results();
    end
    $display("calibration test done");
    xfer(1'h0, 32'h6c, 8'h0, q, e);
    chk("slverr", e, 32'h1);
    chk("unmapped", q, 32'h0);
    $display("unmapped test done");
    results();
  end
endmodule
